// ==== gigabit_phy_mgmt_regs.sv ====
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - test mode field selects transmitter test
// - manual enable overrides automatic master/slave resolution
// - manual value: 0 slave, 1 master
// - port type bit: single or multi port
// - advertise gigabit full/half duplex, reset one
// - configuration fault bit latches high
// - resolution bit reports master or slave
// - local and remote receiver ok bits
// - partner advertised full/half duplex bits
// - idle error counter, clears on read
// - function field selects address or data
// - no address increment on writes
// - five bit device select field
// - address/data holds address or data
// - extended ability: fibre 0, twisted pair 1
module gigabit_phy_mgmt_regs
   import gphy_regs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire phy_status_t status_in,
   input wire logic auto_master,
   output phy_ctrl_t ctrl_out,
   output logic master_sel,
   output ind_req_t ind_req,
   input wire logic [15:0] ind_rdata,
   output logic irq
);

   // =====================================================
   // pin synchronisers (three stages, change on agreement)
   logic [6:0] sync1_reg;
   logic [6:0] sync2_reg;
   logic [6:0] sync3_reg;
   logic [6:0] live_reg;
   logic [6:0] live_next;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_reg <= 7'h00;
         sync2_reg <= 7'h00;
         sync3_reg <= 7'h00;
      end
      else
      begin
         sync1_reg <= status_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++)
      begin : g_agree
         assign live_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ? sync3_reg[gi] : live_reg[gi];
      end
   endgenerate

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         live_reg <= 7'h00;
      else
         live_reg <= live_next;
   end

   phy_status_t live;
   assign live = live_reg;

   logic idle_err_prev_reg;
   logic idle_err_pulse;
   logic rx_ok_prev_reg;
   logic rx_chg_pulse;
   assign idle_err_pulse = live.idle_err & ~idle_err_prev_reg;
   assign rx_chg_pulse = live.local_rx_ok ^ rx_ok_prev_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         idle_err_prev_reg <= 1'b0;
         rx_ok_prev_reg <= 1'b0;
      end
      else
      begin
         idle_err_prev_reg <= live.idle_err;
         rx_ok_prev_reg <= live.local_rx_ok;
      end
   end

   // =====================================================
   // gigabit control
   logic [2:0] test_mode_reg;
   logic ms_en_reg;
   logic ms_val_reg;
   logic port_reg;
   logic adv_fd_reg;
   logic adv_hd_reg;
   logic wr_ctrl;
   assign wr_ctrl = wr && (addr == ADDR_GIG_CTRL);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         test_mode_reg <= TEST_MODE_RST;
         ms_en_reg <= 1'b0;
         ms_val_reg <= 1'b0;
         port_reg <= 1'b0;
         adv_fd_reg <= ADV_FD_RST;
         adv_hd_reg <= ADV_HD_RST;
      end
      else if (wr_ctrl)
      begin
         test_mode_reg <= wdata[CTRL_TEST_LSB +: 3];
         ms_en_reg <= wdata[CTRL_MS_EN];
         ms_val_reg <= wdata[CTRL_MS_VAL];
         port_reg <= wdata[CTRL_PORT];
         adv_fd_reg <= wdata[CTRL_FD];
         adv_hd_reg <= wdata[CTRL_HD];
      end
   end

   always_comb
   begin
      ctrl_out.test_mode = test_mode_reg;
      // reserved codes pass through unchanged with test_mode_valid cleared
      case (test_mode_reg)
         TM_NORMAL, TM_WAVEFORM, TM_JITTER_MASTER, TM_JITTER_SLAVE, TM_DISTORTION:
            ctrl_out.test_mode_valid = 1'b1;
         default:
            ctrl_out.test_mode_valid = 1'b0;
      endcase
      ctrl_out.ms_manual = ms_en_reg;
      ctrl_out.ms_force_master = ms_en_reg & ms_val_reg;
      ctrl_out.multi_port = port_reg;
      ctrl_out.adv_fd = adv_fd_reg;
      ctrl_out.adv_hd = adv_hd_reg;
   end

   // manual value ignored unless enabled
   assign master_sel = ms_en_reg ? ms_val_reg : auto_master;

   // =====================================================
   // gigabit status
   logic fault_latch_reg;
   logic [7:0] idle_cnt_reg;
   logic rd_stat;
   assign rd_stat = rd && (addr == ADDR_GIG_STAT);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         fault_latch_reg <= 1'b0;
      else if (live.ms_fault)
         fault_latch_reg <= 1'b1;
      else if (rd_stat)
         fault_latch_reg <= 1'b0;
   end

   // saturates so a burst cannot wrap to a low count
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         idle_cnt_reg <= IDLE_ERR_RST;
      else if (rd_stat)
         idle_cnt_reg <= idle_err_pulse ? 8'h01 : IDLE_ERR_RST;
      else if (idle_err_pulse && idle_cnt_reg != IDLE_ERR_MAX)
         idle_cnt_reg <= idle_cnt_reg + 8'h01;
   end

   logic [15:0] stat_word;
   assign stat_word = {fault_latch_reg | live.ms_fault,
                       live.resolved_master,
                       live.local_rx_ok, live.remote_rx_ok,
                       live.partner_fd, live.partner_hd,
                       2'b00, idle_cnt_reg};

   // =====================================================
   // indirect access pair
   logic [1:0] fn_reg;
   logic [4:0] dev_reg;
   logic [15:0] ind_addr_reg;
   logic wr_ictl;
   logic data_acc;
   logic wr_data;
   logic rd_data;
   assign wr_ictl = wr && (addr == ADDR_IND_CTRL);
   assign data_acc = (fn_reg != FN_ADDRESS);
   assign wr_data = wr && (addr == ADDR_IND_DATA);
   assign rd_data = rd && (addr == ADDR_IND_DATA);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fn_reg <= FN_ADDRESS;
         dev_reg <= IND_DEV_RST;
      end
      else if (wr_ictl)
      begin
         fn_reg <= wdata[15:14];
         dev_reg <= wdata[4:0];
      end
   end

   // only reads advance the address; writes never do
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ind_addr_reg <= IND_DATA_RST;
      else if (wr_data && !data_acc)
         ind_addr_reg <= wdata;
      else if (rd_data && fn_reg == FN_DATA_INC_RW)
         ind_addr_reg <= ind_addr_reg + 16'h0001;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ind_req <= '0;
      else
      begin
         ind_req.wr <= wr_data && data_acc;
         ind_req.rd <= rd_data && data_acc;
         ind_req.dev <= dev_reg;
         ind_req.addr <= ind_addr_reg;
         ind_req.wdata <= wdata;
      end
   end

   // =====================================================
   // interrupt status and mask
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_set;
   assign irq_set[IRQ_FAULT] = live.ms_fault;
   assign irq_set[IRQ_RX_CHG] = rx_chg_pulse;
   assign irq_set[IRQ_IDLE_ERR] = idle_err_pulse;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_stat_reg <= '0;
      else if (wr && addr == ADDR_IRQ_STAT)
         irq_stat_reg <= (irq_stat_reg & ~wdata[IRQ_W-1:0]) | irq_set;
      else
         irq_stat_reg <= irq_stat_reg | irq_set;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_mask_reg <= '0;
      else if (wr && addr == ADDR_IRQ_MASK)
         irq_mask_reg <= wdata[IRQ_W-1:0];
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   // =====================================================
   // read data, one cycle after the strobe
   logic [15:0] rd_mux;
   always_comb
   begin
      case (addr)
         ADDR_GIG_CTRL:
            rd_mux = {test_mode_reg, ms_en_reg, ms_val_reg, port_reg,
                      adv_fd_reg, adv_hd_reg, 8'h00};
         ADDR_GIG_STAT:
            rd_mux = stat_word;
         ADDR_IND_CTRL:
            rd_mux = {fn_reg, 9'h000, dev_reg};
         ADDR_IND_DATA:
            rd_mux = data_acc ? ind_rdata : ind_addr_reg;
         ADDR_EXT_ABIL:
            rd_mux = EXT_ABIL_VAL;
         ADDR_IRQ_STAT:
            rd_mux = {13'h0000, irq_stat_reg};
         ADDR_IRQ_MASK:
            rd_mux = {13'h0000, irq_mask_reg};
         default:
            rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata <= 16'h0000;
      else if (rd)
         rdata <= rd_mux;
      else
         rdata <= 16'h0000;
   end

endmodule
`default_nettype wire

// ==== gphy_regs_chk_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module gphy_regs_chk
   import gphy_regs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire phy_status_t status_in,
   input wire logic auto_master,
   input wire phy_ctrl_t ctrl_out,
   input wire logic master_sel,
   input wire ind_req_t ind_req,
   input wire logic [15:0] ind_rdata,
   input wire logic irq
);
   // ======================================
   // function and device as last written
   logic [6:0] sel_q;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sel_q <= 7'h00;
      else if (wr && addr == ADDR_IND_CTRL)
         sel_q <= {wdata[15:14], wdata[4:0]};
   end
   // ======================================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_ext_ability: assert property (
      $past(rd) && $past(addr) == ADDR_EXT_ABIL |-> rdata == 16'h3000)
      else $error("extended ability word wrong");
   a_test_valid: assert property (
      ctrl_out.test_mode_valid == (ctrl_out.test_mode < 3'h5))
      else $error("reserved test code not flagged");
   a_master_select: assert property (
      master_sel == (ctrl_out.ms_manual ? ctrl_out.ms_force_master : auto_master))
      else $error("master select wrong");
   a_ctrl_write: assert property (
      wr && addr == ADDR_GIG_CTRL |=> ctrl_out.test_mode == $past(wdata[15:13])
      && {ctrl_out.multi_port, ctrl_out.adv_fd, ctrl_out.adv_hd} == $past(wdata[10:8]))
      else $error("control write not applied");
   a_ind_write: assert property (
      ind_req.wr |-> $past(wr) && $past(addr) == ADDR_IND_DATA && $past(sel_q[6:5]) != 2'h0)
      else $error("indirect write without data access");
   a_no_wr_inc: assert property (
      ind_req.wr ##1 ind_req.wr |-> ind_req.addr == $past(ind_req.addr))
      else $error("address moved on write");
   a_rd_post_inc: assert property (
      ind_req.rd ##1 ind_req.rd |-> ind_req.addr == $past(ind_req.addr)
      + {15'h0000, sel_q[6:5] == 2'h2})
      else $error("read increment wrong");
   a_dev_select: assert property (
      ind_req.rd || ind_req.wr |-> ind_req.dev == sel_q[4:0])
      else $error("device select wrong");
   c_rd_pair: cover property (ind_req.rd ##1 ind_req.rd);
   c_wr_pair: cover property (ind_req.wr ##1 ind_req.wr);
   c_irq: cover property (irq);
endmodule
bind gigabit_phy_mgmt_regs gphy_regs_chk u_gphy_regs_chk (.clk(clk), .rst(rst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .status_in(status_in),
   .auto_master(auto_master), .ctrl_out(ctrl_out), .master_sel(master_sel),
   .ind_req(ind_req), .ind_rdata(ind_rdata), .irq(irq));
`default_nettype wire

// ==== gphy_regs_pkg.sv ====
package gphy_regs_pkg;
   // =====================================================
   // register map (word index, one register per address)
   localparam logic [4:0] ADDR_GIG_CTRL = 5'h09;
   localparam logic [4:0] ADDR_GIG_STAT = 5'h0A;
   localparam logic [4:0] ADDR_IND_CTRL = 5'h0D;
   localparam logic [4:0] ADDR_IND_DATA = 5'h0E;
   localparam logic [4:0] ADDR_EXT_ABIL = 5'h0F;
   localparam logic [4:0] ADDR_IRQ_STAT = 5'h1A;
   localparam logic [4:0] ADDR_IRQ_MASK = 5'h1B;

   // =====================================================
   // reset values
   localparam logic [2:0] TEST_MODE_RST = 3'h0;
   localparam logic ADV_FD_RST = 1'b1;
   localparam logic ADV_HD_RST = 1'b1;
   localparam logic [15:0] IND_DATA_RST = 16'h0000;
   localparam logic [4:0] IND_DEV_RST = 5'h00;
   localparam logic [7:0] IDLE_ERR_RST = 8'h00;
   localparam logic [7:0] IDLE_ERR_MAX = 8'hFF;
   localparam logic [15:0] EXT_ABIL_VAL = 16'h3000;

   // =====================================================
   // field positions
   localparam int CTRL_TEST_LSB = 13;
   localparam int CTRL_MS_EN = 12;
   localparam int CTRL_MS_VAL = 11;
   localparam int CTRL_PORT = 10;
   localparam int CTRL_FD = 9;
   localparam int CTRL_HD = 8;
   localparam int IRQ_W = 3;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_RX_CHG = 1;
   localparam int IRQ_IDLE_ERR = 2;

   typedef enum logic [2:0] {
      TM_NORMAL = 3'h0,
      TM_WAVEFORM = 3'h1,
      TM_JITTER_MASTER = 3'h2,
      TM_JITTER_SLAVE = 3'h3,
      TM_DISTORTION = 3'h4
   } test_mode_t;

   typedef enum logic [1:0] {
      FN_ADDRESS = 2'h0,
      FN_DATA = 2'h1,
      FN_DATA_INC_RW = 2'h2,
      FN_DATA_INC_WR = 2'h3
   } ind_fn_t;

   // live status from the phy datapath
   typedef struct packed {
      logic ms_fault;
      logic resolved_master;
      logic local_rx_ok;
      logic remote_rx_ok;
      logic partner_fd;
      logic partner_hd;
      logic idle_err;
   } phy_status_t;

   // settings driven into the phy datapath
   typedef struct packed {
      logic [2:0] test_mode;
      logic test_mode_valid;
      logic ms_manual;
      logic ms_force_master;
      logic multi_port;
      logic adv_fd;
      logic adv_hd;
   } phy_ctrl_t;

   // indirect access strobe toward the manageable devices
   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] dev;
      logic [15:0] addr;
      logic [15:0] wdata;
   } ind_req_t;
endpackage

// ==== mmd_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mmd_model
   import gphy_regs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire ind_req_t ind_req,
   output logic [15:0] ind_rdata
);
   // one cell for all addresses: written data must come back on read
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ind_rdata <= 16'h0000;
      else if (ind_req.wr)
         ind_rdata <= ind_req.wdata;
   end
endmodule
`default_nettype wire

// ==== tb_gigabit_phy_mgmt_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_gigabit_phy_mgmt_regs import gphy_regs_pkg::*;;
   logic clk, rst, wr, rd, auto_master, master_sel, irq;
   logic [4:0] addr;
   logic [15:0] wdata, rdata, ind_rdata;
   phy_status_t st;
   phy_ctrl_t ctrl_out;
   ind_req_t ind_req;
   int n_errors = 0, n_compared = 0, cyc = 0;
   gigabit_phy_mgmt_regs u_gigabit_phy_mgmt_regs (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .status_in(st),
      .auto_master(auto_master), .ctrl_out(ctrl_out), .master_sel(master_sel),
      .ind_req(ind_req), .ind_rdata(ind_rdata), .irq(irq));
   mmd_model u_mmd_model (.clk(clk), .rst(rst), .ind_req(ind_req), .ind_rdata(ind_rdata));
   // ======================================
   // bus tasks; wr stays up so writes can run back to back
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1; rd <= 1'b0; addr <= a; wdata <= d;
   endtask
   task automatic idle;
      @(posedge clk);
      wr <= 1'b0; rd <= 1'b0;
      #1;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk);
      wr <= 1'b0; rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   task automatic rd2(input logic [4:0] a, input logic [15:0] e1, input logic [15:0] e2);
      @(posedge clk);
      wr <= 1'b0; rd <= 1'b1; addr <= a;
      @(posedge clk);
      #1 `CHK(rdata, e1)
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e2)
   endtask
   // ======================================
   // scenarios
   task automatic t_reset;
      `CHK(ctrl_out, 9'h023)
      rd_chk(ADDR_GIG_CTRL, 16'h0300);
      rd_chk(ADDR_GIG_STAT, 16'h0000);
      rd_chk(ADDR_IND_CTRL, 16'h0000);
      rd_chk(ADDR_IND_DATA, 16'h0000);
      rd_chk(ADDR_EXT_ABIL, 16'h3000);
      wr_reg(ADDR_EXT_ABIL, 16'hFFFF);
      wr_reg(5'h05, 16'hFFFF);
      rd_chk(ADDR_EXT_ABIL, 16'h3000);
      rd_chk(5'h05, 16'h0000);
   endtask
   task automatic t_ctrl;
      logic [15:0] w[4] = '{16'h1B00, 16'h1000, 16'h0800, 16'h0800};
      logic [3:0] am = 4'b0110, ex = 4'b0101;
      for (int i = 0; i < 8; i++)
      begin
         wr_reg(ADDR_GIG_CTRL, {i[2:0], 13'h0300});
         idle;
         `CHK(ctrl_out.test_mode, i[2:0])
         `CHK(ctrl_out.test_mode_valid, i < 5)
      end
      for (int k = 0; k < 4; k++)
      begin
         wr_reg(ADDR_GIG_CTRL, w[k]);
         auto_master <= am[k];
         idle;
         `CHK(master_sel, ex[k])
      end
      wr_reg(ADDR_GIG_CTRL, 16'h04FF);
      rd_chk(ADDR_GIG_CTRL, 16'h0400);
      `CHK({ctrl_out.multi_port, ctrl_out.adv_fd, ctrl_out.adv_hd}, 3'b100)
   endtask
   task automatic t_status;
      wr_reg(ADDR_IRQ_MASK, 16'h0001);
      idle;
      st <= 7'b0110100;
      wait_n(8);
      rd_chk(ADDR_GIG_STAT, 16'h6800);
      st.ms_fault <= 1'b1;
      wait_n(8);
      st.ms_fault <= 1'b0;
      wait_n(8);
      `CHK(irq, 1'b1)
      rd_chk(ADDR_GIG_STAT, 16'hE800);
      rd_chk(ADDR_GIG_STAT, 16'h6800);
      rd_chk(ADDR_IRQ_STAT, 16'h0003);
      wr_reg(ADDR_IRQ_STAT, 16'h0007);
      idle;
      `CHK(irq, 1'b0)
      repeat (3)
      begin
         st.idle_err <= 1'b1;
         wait_n(8);
         st.idle_err <= 1'b0;
         wait_n(8);
      end
      `CHK(irq, 1'b0)
      rd_chk(ADDR_IRQ_STAT, 16'h0004);
      wr_reg(ADDR_IRQ_MASK, 16'h0004);
      idle;
      `CHK(irq, 1'b1)
      rd_chk(ADDR_GIG_STAT, 16'h6803);
      rd_chk(ADDR_GIG_STAT, 16'h6800);
   endtask
   task automatic t_indirect;
      wr_reg(ADDR_IND_CTRL, 16'h0003);
      wr_reg(ADDR_IND_DATA, 16'h0040);
      wr_reg(ADDR_IND_CTRL, 16'h8003);
      wr_reg(ADDR_IND_DATA, 16'h1234);
      wr_reg(ADDR_IND_DATA, 16'h5678);
      idle;
      rd_chk(ADDR_IND_DATA, 16'h5678);
      rd2(ADDR_IND_DATA, 16'h5678, 16'h5678);
      rd_chk(ADDR_IND_CTRL, 16'h8003);
      wr_reg(ADDR_IND_CTRL, 16'h4003);
      rd_chk(ADDR_IND_DATA, 16'h5678);
      wr_reg(ADDR_IND_CTRL, 16'hC003);
      rd_chk(ADDR_IND_DATA, 16'h5678);
      wr_reg(ADDR_IND_DATA, 16'h9ABC);
      idle;
      rd_chk(ADDR_IND_DATA, 16'h9ABC);
      wr_reg(ADDR_IND_CTRL, 16'h0003);
      rd_chk(ADDR_IND_DATA, 16'h0043);
   endtask
   // ======================================
   // run control
   task automatic test_done;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // whole run is under a thousand cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_errors++;
         test_done;
      end
   end
   initial
   begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 5'h00; wdata = 16'h0000;
      st = '0; auto_master = 1'b0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      #1;
      t_reset;
      t_ctrl;
      t_status;
      t_indirect;
      test_done;
   end
endmodule
`default_nettype wire
